/* File: verilog/ppmt_timer.sv */
/*
  Pulse period measurement timer: 8-bit prescaler and 8-bit down counter
  with edge-triggered capture and reload, flags, interrupts, AHB-Lite
  registers. Assumes one 100 MHz clock; oscillator, sub-clock and pins
  are asynchronous and are synchronised here.
*/
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module ppmt_timer
  import ppmt_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Count clocks from outside this domain
  input wire logic onchip_osc_clock,
  input wire logic subclock,
  // Measured pulse pins
  input wire logic alt_input_pin_a,
  input wire logic alt_input_pin_b,
  // Interrupt
  output logic irq
);

  // ==========================================================
  // State
  typedef struct packed {
    logic run;
    logic [7:0] pre_cnt;
    logic [7:0] pre_rld;
    logic [7:0] tmr_cnt;
    logic [7:0] tmr_rld;
    logic [7:0] rbuf;
    logic buf_full;
    logic edge_flag;
    logic undf_flag;
    logic edge_pol;
    logic pin_sel;
    logic [1:0] filt_sel;
    logic [2:0] src_sel;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    ppmt_cap_t cap;
    logic div2;
    logic [2:0] div8;
    logic [4:0] div32;
    logic [4:0] sub_cnt;
    logic osc_prev;
    logic sub_prev;
    logic pulse_prev;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } ppmt_state_t;

  ppmt_state_t r_reg;
  ppmt_state_t r_next;

  ppmt_async_t async_in;
  ppmt_async_t sync_out;
  ppmt_ahb_req_t req;
  logic pulse_raw;
  logic pulse_filt;
  logic filt_sample;

  // ==========================================================
  // Input synchronisation and filtering
  assign async_in = '{pin_a: alt_input_pin_a, pin_b: alt_input_pin_b,
                      osc: onchip_osc_clock, sub: subclock};

  ppmt_sync2 #(
    .WIDTH($bits(ppmt_async_t))
  ) i_ppmt_sync2 (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(async_in),
    .q(sync_out)
  );

  // Pin choice ahead of the filter
  assign pulse_raw = r_reg.pin_sel ? sync_out.pin_b : sync_out.pin_a;

  // Sampling rate of the filter
  always_comb begin
    case (r_reg.filt_sel)
      PPMT_FILT_DIV1: filt_sample = 1'b1;
      PPMT_FILT_DIV8: filt_sample = (r_reg.div8 == PPMT_DIV8_LAST);
      PPMT_FILT_DIV32: filt_sample = (r_reg.div32 == PPMT_DIV32_LAST);
      default: filt_sample = 1'b0;
    endcase
  end

  ppmt_filter i_ppmt_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .bypass(r_reg.filt_sel == PPMT_FILT_OFF),
    .sample(filt_sample),
    .din(pulse_raw),
    .dout(pulse_filt)
  );

  assign req = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite,
                 hsize: hsize, hready: hready};

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic tick;
    logic osc_rise;
    logic sub_rise;
    logic pre_uf;
    logic tmr_uf;
    logic act_edge;
    logic edge_set;
    logic undf_set;
    logic reload_ev;
    logic accept;
    logic [31:0] wd;
    tick = 1'b0;
    osc_rise = 1'b0;
    sub_rise = 1'b0;
    pre_uf = 1'b0;
    tmr_uf = 1'b0;
    act_edge = 1'b0;
    edge_set = 1'b0;
    undf_set = 1'b0;
    reload_ev = 1'b0;
    accept = 1'b0;
    wd = hwdata;
    r_next = r_reg;

    // Free-running dividers of the system clock
    r_next.div2 = ~r_reg.div2;
    r_next.div8 = r_reg.div8 + 3'h1;
    r_next.div32 = r_reg.div32 + 5'h01;
    r_next.osc_prev = sync_out.osc;
    r_next.sub_prev = sync_out.sub;
    osc_rise = sync_out.osc & ~r_reg.osc_prev;
    sub_rise = sync_out.sub & ~r_reg.sub_prev;
    if (sub_rise) begin
      r_next.sub_cnt = r_reg.sub_cnt + 5'h01;
    end

    // Count source selection
    case (r_reg.src_sel)
      PPMT_SRC_DIV1: tick = 1'b1;
      PPMT_SRC_DIV2: tick = r_reg.div2;
      PPMT_SRC_DIV8: tick = (r_reg.div8 == PPMT_DIV8_LAST);
      PPMT_SRC_OSC: tick = osc_rise;
      PPMT_SRC_SUB32: tick = sub_rise && (r_reg.sub_cnt == PPMT_DIV32_LAST);
      default: tick = 1'b0;
    endcase

    // Active edge of the filtered pulse, polarity chosen by software
    r_next.pulse_prev = pulse_filt;
    act_edge = r_reg.run && (r_reg.edge_pol ?
               (r_reg.pulse_prev & ~pulse_filt) :
               (~r_reg.pulse_prev & pulse_filt));

    // Prescaler with self reload; its underflow steps the counter
    if (r_reg.run && tick) begin
      if (r_reg.pre_cnt == 8'h00) begin
        pre_uf = 1'b1;
        r_next.pre_cnt = r_reg.pre_rld;
      end else begin
        r_next.pre_cnt = r_reg.pre_cnt - 8'h01;
      end
    end
    if (pre_uf) begin
      if (r_reg.tmr_cnt == 8'h00) begin
        tmr_uf = 1'b1;
        r_next.tmr_cnt = r_reg.tmr_rld;
      end else begin
        r_next.tmr_cnt = r_reg.tmr_cnt - 8'h01;
      end
    end
    undf_set = tmr_uf;

    // Capture then reload on the two underflows following an edge
    case (r_reg.cap)
      PPMT_CAP_IDLE: begin
        if (act_edge) begin
          r_next.cap = PPMT_CAP_ARMED;
        end
      end
      PPMT_CAP_ARMED: begin
        if (pre_uf) begin
          // An unread result is kept; the newer one is lost
          if (!r_reg.buf_full) begin
            r_next.rbuf = r_reg.tmr_cnt;
            r_next.buf_full = 1'b1;
          end
          r_next.cap = PPMT_CAP_DONE;
        end
      end
      PPMT_CAP_DONE: begin
        if (pre_uf) begin
          r_next.tmr_cnt = r_reg.tmr_rld;
          reload_ev = 1'b1;
          edge_set = 1'b1;
          r_next.cap = PPMT_CAP_IDLE;
        end
      end
      default: r_next.cap = PPMT_CAP_IDLE;
    endcase
    if (!r_reg.run) begin
      r_next.cap = PPMT_CAP_IDLE;
    end

    // ========================================================
    // AHB-Lite address phase: zero wait states, always OKAY
    accept = req.hsel && req.hready && req.htrans[1];
    r_next.wr_pend = accept && req.hwrite;
    r_next.wr_addr = req.haddr[7:0];
    if (accept && !req.hwrite) begin
      case (req.haddr[7:0])
        PPMT_CTRL_OFS: r_next.rdata = 32'({r_reg.undf_flag,
          r_reg.edge_flag, 2'h0, r_reg.run, r_reg.run});
        PPMT_PINIO_OFS: r_next.rdata = 32'({r_reg.filt_sel, 1'b0,
          r_reg.pin_sel, 1'b0, r_reg.edge_pol});
        PPMT_SRC_OFS: r_next.rdata = 32'(r_reg.src_sel);
        PPMT_PRE_OFS: r_next.rdata = 32'(r_reg.pre_cnt);
        PPMT_PERIOD_OFS: begin
          r_next.rdata = 32'(r_reg.rbuf);
          r_next.buf_full = 1'b0;
        end
        PPMT_IRQ_STAT_OFS: r_next.rdata = 32'(r_reg.irq_stat);
        PPMT_IRQ_MASK_OFS: r_next.rdata = 32'(r_reg.irq_mask);
        default: r_next.rdata = 32'h0000_0000;
      endcase
      // A capture in this same cycle still lands in the buffer; only
      // when it was free, else a value already read would stay locked
      if (req.haddr[7:0] == PPMT_PERIOD_OFS && r_reg.cap == PPMT_CAP_ARMED
          && pre_uf && !r_reg.buf_full) begin
        r_next.buf_full = 1'b1;
      end
    end

    // AHB-Lite data phase writes
    if (r_reg.wr_pend) begin
      case (r_reg.wr_addr)
        PPMT_CTRL_OFS: begin
          r_next.run = wd[PPMT_RUN_BIT];
          if (wd[PPMT_HALT_BIT]) begin
            r_next.run = 1'b0;
            r_next.cap = PPMT_CAP_IDLE;
          end
          // Flags clear on a written zero, a written one leaves them
          r_next.edge_flag = r_reg.edge_flag & wd[PPMT_EDGEF_BIT];
          r_next.undf_flag = r_reg.undf_flag & wd[PPMT_UNDF_BIT];
        end
        PPMT_PINIO_OFS: begin
          r_next.edge_pol = wd[PPMT_POL_BIT];
          r_next.pin_sel = wd[PPMT_PINSEL_BIT];
          r_next.filt_sel = wd[PPMT_FILT_LSB+1:PPMT_FILT_LSB];
        end
        PPMT_SRC_OFS: r_next.src_sel = wd[2:0];
        PPMT_PRE_OFS: begin
          // Same path whether running or stopped
          r_next.pre_rld = wd[7:0];
          r_next.pre_cnt = wd[7:0];
        end
        PPMT_PERIOD_OFS: begin
          r_next.tmr_rld = wd[7:0];
          r_next.tmr_cnt = wd[7:0];
        end
        PPMT_IRQ_STAT_OFS: r_next.irq_stat = r_reg.irq_stat & ~wd[2:0];
        PPMT_IRQ_MASK_OFS: r_next.irq_mask = wd[2:0];
        default: ;
      endcase
    end

    // Hardware sets applied last so a same-cycle clear loses
    if (undf_set) begin
      r_next.undf_flag = 1'b1;
      r_next.irq_stat[PPMT_IRQ_UNDF] = 1'b1;
    end
    if (edge_set) begin
      r_next.edge_flag = 1'b1;
    end
    if (reload_ev) begin
      r_next.irq_stat[PPMT_IRQ_RELOAD] = 1'b1;
    end
    if (act_edge) begin
      r_next.irq_stat[PPMT_IRQ_EDGE] = 1'b1;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '{run: 1'b0, pre_cnt: PPMT_PRE_RST, pre_rld: PPMT_PRE_RST,
                 tmr_cnt: PPMT_TMR_RST, tmr_rld: PPMT_TMR_RST,
                 rbuf: 8'h00, buf_full: 1'b0, edge_flag: 1'b0,
                 undf_flag: 1'b0, edge_pol: 1'b0, pin_sel: 1'b0,
                 filt_sel: PPMT_FILT_OFF, src_sel: PPMT_SRC_DIV1,
                 irq_stat: 3'h0, irq_mask: PPMT_IRQ_MASK_RST,
                 cap: PPMT_CAP_IDLE, div2: 1'b0, div8: 3'h0,
                 div32: 5'h00, sub_cnt: 5'h00, osc_prev: 1'b0,
                 sub_prev: 1'b0, pulse_prev: 1'b0, wr_pend: 1'b0,
                 wr_addr: 8'h00, rdata: 32'h0000_0000};
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // Outputs
  assign hreadyout = 1'b1; // No wait states
  assign hresp = 1'b0;
  assign hrdata = r_reg.rdata;
  assign irq = |(r_reg.irq_stat & r_reg.irq_mask);

endmodule

/* File: verilog/ppmt_pkg.sv */
/*
  Package of the pulse period measurement timer: register byte offsets,
  field positions, reset values, state codes and the bundled types.
  Assumes a 32-bit AHB-Lite register bus and a single 100 MHz clock.
*/
package ppmt_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] PPMT_CTRL_OFS = 8'h00;
  localparam logic [7:0] PPMT_PINIO_OFS = 8'h04;
  localparam logic [7:0] PPMT_SRC_OFS = 8'h08;
  localparam logic [7:0] PPMT_PRE_OFS = 8'h0C;
  localparam logic [7:0] PPMT_PERIOD_OFS = 8'h10;
  localparam logic [7:0] PPMT_IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] PPMT_IRQ_MASK_OFS = 8'h18;

  // ==========================================================
  // Control register fields
  localparam int PPMT_RUN_BIT = 0;
  localparam int PPMT_ACTIVE_BIT = 1;
  localparam int PPMT_HALT_BIT = 2;
  localparam int PPMT_EDGEF_BIT = 4;
  localparam int PPMT_UNDF_BIT = 5;

  // Pin control fields
  localparam int PPMT_POL_BIT = 0;
  localparam int PPMT_PINSEL_BIT = 2;
  localparam int PPMT_FILT_LSB = 4;

  // Interrupt status and mask fields
  localparam int PPMT_IRQ_UNDF = 0;
  localparam int PPMT_IRQ_RELOAD = 1;
  localparam int PPMT_IRQ_EDGE = 2;

  // ==========================================================
  // Count source and filter codes
  localparam logic [2:0] PPMT_SRC_DIV1 = 3'h0;
  localparam logic [2:0] PPMT_SRC_DIV2 = 3'h1;
  localparam logic [2:0] PPMT_SRC_DIV8 = 3'h2;
  localparam logic [2:0] PPMT_SRC_OSC = 3'h3;
  localparam logic [2:0] PPMT_SRC_SUB32 = 3'h4;
  localparam logic [1:0] PPMT_FILT_OFF = 2'h0;
  localparam logic [1:0] PPMT_FILT_DIV1 = 2'h1;
  localparam logic [1:0] PPMT_FILT_DIV8 = 2'h2;
  localparam logic [1:0] PPMT_FILT_DIV32 = 2'h3;
  localparam logic [2:0] PPMT_DIV8_LAST = 3'h7;
  localparam logic [4:0] PPMT_DIV32_LAST = 5'h1F;

  // Reset values
  localparam logic [7:0] PPMT_PRE_RST = 8'hFF;
  localparam logic [7:0] PPMT_TMR_RST = 8'hFF;
  localparam logic [2:0] PPMT_IRQ_MASK_RST = 3'h0;

  // ==========================================================
  // Capture sequence after an active edge
  typedef enum logic [2:0] {
    PPMT_CAP_IDLE = 3'b001,
    PPMT_CAP_ARMED = 3'b010,
    PPMT_CAP_DONE = 3'b100
  } ppmt_cap_t;

  // AHB-Lite request as seen by the slave
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
  } ppmt_ahb_req_t;

  // Raw inputs from outside the clock domain
  typedef struct packed {
    logic pin_a;
    logic pin_b;
    logic osc;
    logic sub;
  } ppmt_async_t;

endpackage

/* File: verilog/ppmt_sync2.sv */
/*
  Two-flop synchroniser for a bundle of asynchronous levels.
  Assumes only the second stage is read by any logic downstream.
*/
`timescale 1ns/10ps
module ppmt_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stage2;
  } ppmt_sync_state_t;

  ppmt_sync_state_t s_reg;
  ppmt_sync_state_t s_next;

  // ==========================================================
  // Stage one feeds only stage two
  always_comb begin
    s_next.meta = d;
    s_next.stage2 = s_reg.meta;
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.stage2; // Only the second stage leaves

endmodule

/* File: verilog/ppmt_filter.sv */
/*
  Digital filter for the measured pulse: a level passes once three
  consecutive samples agree. Assumes a synchronised input and a sample
  strobe from the same clock; bypass makes the output follow the input.
*/
`timescale 1ns/10ps
module ppmt_filter (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic bypass,
  input wire logic sample,
  // Data
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic [2:0] hist;
    logic out;
  } ppmt_filt_state_t;

  ppmt_filt_state_t f_reg;
  ppmt_filt_state_t f_next;

  // ==========================================================
  // Three-sample history; glitches shorter than that are dropped
  always_comb begin
    f_next = f_reg;
    if (sample) begin
      f_next.hist = {f_reg.hist[1:0], din};
    end
    if (bypass) begin
      f_next.out = din;
    end else if (&f_reg.hist) begin
      f_next.out = 1'b1;
    end else if (~|f_reg.hist) begin
      f_next.out = 1'b0;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end

  assign dout = f_reg.out;

endmodule

/* File: sim/ppmt_pulse_src.sv */
/*
  Far-side model: pulse source on the measured pins, plus free-running
  oscillator and sub-clock. Assumes the bench calls its tasks.
*/
`timescale 1ns/10ps
module ppmt_pulse_src (
  // Measured pins
  output logic pin_a,
  output logic pin_b,
  // Slow clocks
  output logic osc,
  output logic sub
);
  logic sel = 1'b0;
  logic lvl = 1'b0;
  logic junk = 1'b0;
  // ==========
  // Clocks run free, unrelated to hclk; the unused pin toggles so a
  // wrong pin choice shows up as noise rather than a quiet line
  initial begin
    osc = 1'b0;
    forever #35 osc = ~osc;
  end
  initial begin
    sub = 1'b0;
    forever #25 sub = ~sub;
  end
  always #7 junk = ~junk;
  assign pin_a = sel ? junk : lvl;
  assign pin_b = sel ? lvl : junk;
  // Park the chosen pin at its idle level
  task automatic park(input logic s, input logic idle);
    sel = s;
    lvl = idle;
  endtask
  // Active edge, 1700 ns active, idle to the end of the gap; gaps stay
  // well over two prescaler periods so no edge may be dropped
  task automatic act(input int gap_ns);
    lvl = ~lvl;
    #1700;
    lvl = ~lvl;
    #(gap_ns - 1700);
  endtask
endmodule

/* File: sim/ppmt_timer_checker.sv */
/*
  Checker of the timer's bus and interrupt ports.
  Assumes binding to ppmt_timer with hready fed from hreadyout.
*/
`timescale 1ns/10ps
module ppmt_timer_checker
  import ppmt_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus request
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  // Bus answer and interrupt
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic irq
);
  logic take;
  logic mwr_reg;
  logic mwr_next;
  logic [2:0] mask_reg;
  logic [2:0] mask_next;
  // ==========
  // Shadow mask, updated at the end of a write data phase
  assign take = hsel & hready & htrans[1];
  always_comb begin
    mwr_next = take & hwrite & (haddr[7:0] == PPMT_IRQ_MASK_OFS);
    mask_next = mwr_reg ? hwdata[2:0] : mask_reg;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mwr_reg <= 1'b0;
      mask_reg <= PPMT_IRQ_MASK_RST;
    end else begin
      mwr_reg <= mwr_next;
      mask_reg <= mask_next;
    end
  end
  // ==========
  // Properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd(logic [7:0] a);
    take && !hwrite && haddr[7:0] == a;
  endsequence
  sequence ctl_wr(logic v);
    take && hwrite && haddr[7:0] == PPMT_CTRL_OFS
      ##1 hwdata[PPMT_RUN_BIT] == v && !hwdata[PPMT_HALT_BIT];
  endsequence
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_rdata_holds: assert property (!(take && !hwrite) |=> $stable(hrdata))
    else $error("hrdata moved without a read");
  a_run_starts: assert property (
    ctl_wr(1'b1) ##1 rd(PPMT_CTRL_OFS) |=> hrdata[PPMT_RUN_BIT])
    else $error("run bit not set");
  a_run_stops: assert property (
    ctl_wr(1'b0) ##1 rd(PPMT_CTRL_OFS) |=> !hrdata[PPMT_RUN_BIT])
    else $error("run bit not cleared");
  a_halt_reads0: assert property (
    rd(PPMT_CTRL_OFS) |=> !hrdata[PPMT_HALT_BIT])
    else $error("halt bit read as one");
  a_period_byte: assert property (
    rd(PPMT_PERIOD_OFS) |=> hrdata[31:8] == 24'h0)
    else $error("period read wider than a byte");
  a_pre_byte: assert property (rd(PPMT_PRE_OFS) |=> hrdata[31:8] == 24'h0)
    else $error("prescaler read wider than a byte");
  a_irq_masked: assert property (
    mask_reg == 3'h0 && $past(mask_reg) == 3'h0 |-> !irq)
    else $error("irq high with mask clear");
endmodule

/* File: sim/test_ppmt_timer.sv */
/*
  Self-checking bench of the pulse period measurement timer.
  Assumes the pulse source model and the checker beside the timer.
*/
`timescale 1ns/10ps
module test_ppmt_timer;
  import ppmt_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq, osc, sub, pin_a, pin_b;
  logic [31:0] hrdata;
  logic [31:0] rd;
  int failures = 0;
  int checks = 0;
  ppmt_timer i_ppmt_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .onchip_osc_clock(osc),
    .subclock(sub), .alt_input_pin_a(pin_a), .alt_input_pin_b(pin_b),
    .irq(irq));
  ppmt_pulse_src i_ppmt_pulse_src (.pin_a(pin_a), .pin_b(pin_b),
    .osc(osc), .sub(sub));
  // ==========
  // Bus cycles and comparisons
  always #5 hclk = ~hclk;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= 1'b0;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic eq(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rng(input string n, input logic [7:0] lo, hi,
                     input logic [31:0] g);
    checks++;
    if ((g[31:8] === 24'h0 && g[7:0] >= lo && g[7:0] <= hi) !== 1'b1) begin
      failures++;
      $display("[FAIL] %s expected %h..%h seen %h", n, lo, hi, g);
    end
  endtask
  task automatic chk(input string n, input logic [7:0] a, input logic [31:0] e);
    rdr(a, rd);
    eq(n, e, rd);
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    chk("ctrl", PPMT_CTRL_OFS, 32'h0);
    chk("pinio", PPMT_PINIO_OFS, 32'h0);
    chk("src", PPMT_SRC_OFS, 32'h0);
    chk("pre", PPMT_PRE_OFS, {24'h0, PPMT_PRE_RST});
    chk("period", PPMT_PERIOD_OFS, 32'h0);
    chk("stat", PPMT_IRQ_STAT_OFS, 32'h0);
    chk("mask", PPMT_IRQ_MASK_OFS, {29'h0, PPMT_IRQ_MASK_RST});
    chk("unmapped", 8'h1C, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_count;
    logic [31:0] a;
    wr(PPMT_PRE_OFS, 32'h03);
    chk("pre stopped", PPMT_PRE_OFS, 32'h03);
    wr(PPMT_CTRL_OFS, 32'h01);
    rdr(PPMT_CTRL_OFS, rd);
    eq("run on", 32'h1, {31'h0, rd[PPMT_RUN_BIT]});
    wr(PPMT_PRE_OFS, 32'h80);
    rdr(PPMT_PRE_OFS, rd);
    rng("pre running", 8'h7C, 8'h80, rd);
    repeat (300) @(posedge hclk);
    rdr(PPMT_PRE_OFS, rd);
    rng("pre reload", 8'h00, 8'h80, rd);
    wr(PPMT_CTRL_OFS, 32'h0);
    rdr(PPMT_CTRL_OFS, rd);
    eq("run off", 32'h0, {31'h0, rd[PPMT_RUN_BIT]});
    rdr(PPMT_PRE_OFS, a);
    repeat (8) @(posedge hclk);
    chk("pre frozen", PPMT_PRE_OFS, a);
    wr(PPMT_CTRL_OFS, 32'h01);
    wr(PPMT_CTRL_OFS, 32'h05);
    repeat (8) @(posedge hclk);
    rdr(PPMT_PRE_OFS, a);
    rdr(PPMT_CTRL_OFS, rd);
    eq("halted", 32'h0, {31'h0, rd[PPMT_ACTIVE_BIT]});
    chk("pre halted", PPMT_PRE_OFS, a);
    wr(PPMT_CTRL_OFS, 32'h0);
    $display("t_count done");
  endtask
  // Every source code, then the interrupt raised, masked and cleared
  task automatic t_sources;
    wr(PPMT_PRE_OFS, 32'h0);
    wr(PPMT_PERIOD_OFS, 32'h0);
    for (int s = 0; s < 6; s++) begin
      wr(PPMT_CTRL_OFS, 32'h0);
      wr(PPMT_SRC_OFS, 32'(s));
      wr(PPMT_IRQ_STAT_OFS, 32'h7);
      wr(PPMT_CTRL_OFS, 32'h1);
      repeat (250) @(posedge hclk);
      rdr(PPMT_IRQ_STAT_OFS, rd);
      eq("ticks", {31'h0, s < 5}, {31'h0, rd[PPMT_IRQ_UNDF]});
    end
    wr(PPMT_SRC_OFS, 32'h0);
    repeat (4) @(posedge hclk);
    rdr(PPMT_CTRL_OFS, rd);
    eq("undf flag", 32'h1, {31'h0, rd[PPMT_UNDF_BIT]});
    // Counter sits at zero, so every edge reload is also an underflow
    wr(PPMT_CTRL_OFS, 32'h1);
    i_ppmt_pulse_src.act(2000);
    @(posedge hclk);
    chk("both flags", PPMT_CTRL_OFS, 32'h33);
    chk("uf capture", PPMT_PERIOD_OFS, 32'h0);
    wr(PPMT_IRQ_MASK_OFS, 32'h1);
    repeat (4) @(posedge hclk);
    eq("irq on", 32'h1, {31'h0, irq});
    wr(PPMT_CTRL_OFS, 32'h0);
    wr(PPMT_IRQ_STAT_OFS, 32'h7);
    repeat (4) @(posedge hclk);
    eq("irq off", 32'h0, {31'h0, irq});
    wr(PPMT_IRQ_MASK_OFS, 32'h0);
    $display("t_sources done");
  endtask
  // Pin, polarity and filter from i; edges 500 then 300 clocks apart
  task automatic t_measure(input logic [1:0] i);
    wr(PPMT_CTRL_OFS, 32'h0);
    i_ppmt_pulse_src.park(i[0], i[1]);
    wr(PPMT_PINIO_OFS, {26'h0, i, 1'b0, i[0], 1'b0, i[1]});
    wr(PPMT_PRE_OFS, 32'h0F);
    wr(PPMT_PERIOD_OFS, 32'hFF);
    repeat (120) @(posedge hclk);
    wr(PPMT_CTRL_OFS, 32'h1);
    repeat (150) @(posedge hclk);
    wr(PPMT_CTRL_OFS, 32'h1);
    wr(PPMT_IRQ_STAT_OFS, 32'h7);
    fork
      begin
        i_ppmt_pulse_src.act(5000);
        i_ppmt_pulse_src.act(3000);
        i_ppmt_pulse_src.act(2000);
      end
      begin
        // Wrong polarity would only show after the 170-clock pulse
        repeat (160) @(posedge hclk);
        chk("edge stat", PPMT_IRQ_STAT_OFS, 32'h6);
        chk("edge ctrl", PPMT_CTRL_OFS, 32'h13);
        rdr(PPMT_PERIOD_OFS, rd);
        repeat (830) @(posedge hclk);
        // Reload FF less about 500/16 ticks; third edge must not overwrite
        rdr(PPMT_PERIOD_OFS, rd);
        rng("period", 8'hDC, 8'hE4, rd);
      end
    join
    // The pulse branch ends on an edge instant; step past that edge
    @(posedge hclk);
    $display("t_measure %0d done", i);
  endtask
  // ==========
  // Verdict, watchdog and main sequence
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    $display("[FAIL] watchdog expected done seen hang");
    complete_run();
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_count();
    t_sources();
    for (int i = 0; i < 4; i++) begin
      t_measure(2'(i));
    end
    complete_run();
  end
endmodule
bind ppmt_timer ppmt_timer_checker i_ppmt_timer_checker (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
